// ---- mfi_core_model.sv ----
`timescale 1ns/1ps
module mfi_core_model import mfi_pkg::*; (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire mfi_core_out_s core_out_in,
	input wire logic [3:0] ack_dly_in,
	input wire logic stack_full_in,
	input wire logic sleep_in,
	output mfi_core_in_s core_in_out,
	output int push_cnt_out,
	output int wake_cnt_out,
	output logic [11:0] last_vec_out
);
	logic [3:0] wait_q;
	logic ack_q;
	logic return_from_interrupt_q = 1'b0;

	// stack level and sleep come straight from the bench; the service routine itself is a leaf
	assign core_in_out = {ack_q, return_from_interrupt_q, stack_full_in, sleep_in};

	// accept a vector after a chosen delay, so both quick and slow cores are exercised
	always @(posedge clk_in) begin
		if (!rst_b_in) begin
			wait_q <= 4'h0;
			ack_q <= 1'b0;
			push_cnt_out <= 0;
			wake_cnt_out <= 0;
			last_vec_out <= 12'h000;
		end else begin
			ack_q <= core_out_in.int_req && !ack_q && wait_q == ack_dly_in;
			wait_q <= (core_out_in.int_req && !ack_q && wait_q != ack_dly_in) ? wait_q + 4'h1 : 4'h0;
			if (ack_q && core_out_in.int_req) begin
				last_vec_out <= core_out_in.vec_addr;
			end
			if (core_out_in.push_pc) begin
				push_cnt_out <= push_cnt_out + 1;
			end
			if (core_out_in.wake) begin
				wake_cnt_out <= wake_cnt_out + 1;
			end
		end
	end

	// return from interrupt, one cycle wide, launched just after an edge
	task automatic ret_int;
		@(posedge clk_in);
		return_from_interrupt_q <= 1'b1;
		@(posedge clk_in);
		return_from_interrupt_q <= 1'b0;
	endtask
endmodule // mfi_core_model

// ---- mfi_grp_pick.sv ----
`timescale 1ns/1ps
module mfi_grp_pick import mfi_pkg::*; #(
	parameter int N = NUM_GRP,
	parameter int IW = GRP_W
) (
	input wire logic [N-1:0] req_in,
	output logic any_out,
	output logic [IW-1:0] idx_out
);
	// lowest index wins, matching the vector order
	function automatic logic [IW-1:0] lowest(input logic [N-1:0] r);
		logic [IW-1:0] i;
		i = '0;
		for (int k = N - 1; k >= 0; k--) begin
			if (r[k]) begin
				i = IW'(k);
			end
		end
		return i;
	endfunction

	assign any_out = |req_in;
	assign idx_out = lowest(req_in);
endmodule // mfi_grp_pick

// ---- mfi_pkg.sv ----
// Contract
// - set the serial module flag each time that module finishes one byte.
// - set the second SPI port flag each time that port finishes one byte.
// - vector only with global, source and group enables set and stack not full.
// - service entry clears the global interrupt enable.
// - service entry clears only the group flag; source flags stay set.
// - a falling edge on the active-low peripheral pin sets the peripheral flag.
// - set the nvm flag when a nonvolatile write cycle finishes.
// - set the low supply flag when the monitor reports supply below threshold.
// - each compact timer has period and A match flags with separate enables.
// - each enhanced timer has period, A and B match flags with enables.
// - a timer flag is set when its comparator channel matches.
// - any flag going low to high wakes from sleep or idle, enables ignored.
// - wake detection keeps working while the system oscillator is stopped; here it needs sys_clk_in running.
// - flags are software writable; setting one high beforehand masks its wake.
// - a set flag holds until serviced or cleared; disabling only stops service.
// - a group flag is set whenever one of its member source flags becomes set.
// - on entry only the program counter is pushed onto the return stack.
// - return from interrupt sets the global enable; a plain return does not.
package mfi_pkg;
	localparam int NUM_CTM = 2;
	localparam int NUM_ETM = 2;
	localparam int NUM_GRP = 6;
	localparam int NUM_SRC = 5 + 2 * NUM_CTM + 3 * NUM_ETM;
	localparam int GRP_W = 3;
	// source flag bit positions
	localparam int SRC_SERIAL = 0;
	localparam int SRC_SPI2 = 1;
	localparam int SRC_EXT = 2;
	localparam int SRC_NVM = 3;
	localparam int SRC_LOW = 4;
	localparam int SRC_CTM0 = 5;
	localparam int SRC_ETM0 = SRC_CTM0 + 2 * NUM_CTM;
	// members of each group, group 0 has the lowest vector
	localparam logic [NUM_GRP-1:0][NUM_SRC-1:0] GRP_MASK = {
		15'h0018, 15'h0007, 15'h7000, 15'h0180, 15'h0e00, 15'h0060};
	// register byte offsets
	localparam logic [4:0] OFS_CTRL = 5'h00;
	localparam logic [4:0] OFS_SRC_FLAG = 5'h04;
	localparam logic [4:0] OFS_SRC_EN = 5'h08;
	localparam logic [4:0] OFS_GRP_FLAG = 5'h0c;
	localparam logic [4:0] OFS_GRP_EN = 5'h10;
	localparam logic [4:0] OFS_STATUS = 5'h14;
	// field positions
	localparam int CTRL_GIE = 0;
	localparam int ST_REQ = 0;
	localparam int ST_VEC = 4;
	localparam int ST_FULL = 8;
	localparam int ST_SLEEP = 9;
	localparam int ST_WAKE = 10;
	// reset values
	localparam logic CTRL_GIE_RST = 1'b0;
	localparam logic [NUM_SRC-1:0] SRC_RST = 15'h0000;
	localparam logic [NUM_GRP-1:0] GRP_RST = 6'h00;
	localparam logic PIN_IDLE = 1'b1;
	// vector placement, arbitrary values
	localparam logic [11:0] VEC_BASE = 12'h00c;
	localparam logic [11:0] VEC_STEP = 12'h004;

	typedef struct packed {
		logic read;
		logic write;
		logic [4:0] address;
		logic [3:0] byteenable;
		logic [31:0] writedata;
	} mfi_av_req_s;

	typedef struct packed {
		logic ack;
		logic return_from_interrupt;
		logic stack_full;
		logic sleep;
	} mfi_core_in_s;

	typedef struct packed {
		logic int_req;
		logic push_pc;
		logic wake;
		logic [GRP_W-1:0] grp_idx;
		logic [11:0] vec_addr;
	} mfi_core_out_s;
endpackage

// ---- mfi_sync3.sv ----
`timescale 1ns/1ps
module mfi_sync3 import mfi_pkg::*; #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input wire logic clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	logic [W-1:0] s1_q, s2_q, s3_q, lvl_q, rise_q, fall_q;
	wire logic [W-1:0] agree = ~(s2_q ^ s3_q);
	// a change counts only once stages two and three agree
	wire logic [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

	// s1 feeds s2 only, so metastability never reaches logic
	always_ff @(posedge clk_in) begin
		if (!rst_b_in) begin
			s1_q <= INIT;
			s2_q <= INIT;
			s3_q <= INIT;
			lvl_q <= INIT;
			rise_q <= '0;
			fall_q <= '0;
		end else if (clk_en_in) begin
			s1_q <= async_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			lvl_q <= lvl_d;
			rise_q <= lvl_d & ~lvl_q;
			fall_q <= ~lvl_d & lvl_q;
		end
	end

	assign level_out = lvl_q;
	assign rise_out = rise_q;
	assign fall_out = fall_q;
endmodule // mfi_sync3

// ---- mfi_top.sv ----
// Implementation choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
module mfi_top import mfi_pkg::*; (
	input wire logic sys_clk_in,
	input wire logic rst_b_in,
	input wire logic clk_en_in,
	// avalon-mm slave
	input wire mfi_av_req_s av_req_in,
	output logic [31:0] av_readdata_out,
	output logic av_waitrequest_out,
	// source events
	input wire logic serial_byte_done_in,
	input wire logic spi2_byte_done_in,
	input wire logic periph_int_pin_n_in,
	input wire logic nvm_write_done_in,
	input wire logic supply_low_in,
	input wire logic [2*NUM_CTM-1:0] ctm_match_in,
	input wire logic [3*NUM_ETM-1:0] etm_match_in,
	// processor core sequencer
	input wire mfi_core_in_s core_in,
	output mfi_core_out_s core_out
);
	// byte-lane merge of a register write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		return (old & ~m) | (wd & m);
	endfunction

	logic gie_q;
	logic [NUM_SRC-1:0] src_flag_q, src_en_q;
	logic [NUM_GRP-1:0] grp_flag_q, grp_en_q;
	logic wait_q;
	logic [31:0] rdata_q;
	mfi_core_out_s cout_q;

	// pin and supply monitor come from outside the clock domain
	logic pin_fall, low_rise;
	mfi_sync3 #(.W(1), .INIT(PIN_IDLE)) u_pin_sync (
		.clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.clk_en_in(clk_en_in),
		.async_in(periph_int_pin_n_in),
		.level_out(),
		.rise_out(),
		.fall_out(pin_fall)
	);
	mfi_sync3 #(.W(1), .INIT(1'b0)) u_low_sync (
		.clk_in(sys_clk_in),
		.rst_b_in(rst_b_in),
		.clk_en_in(clk_en_in),
		.async_in(supply_low_in),
		.level_out(),
		.rise_out(low_rise),
		.fall_out()
	);

	// bus decode; access commits at the edge where waitrequest is low
	wire logic acc = (av_req_in.read | av_req_in.write) & ~wait_q;
	wire logic wr = av_req_in.write & acc;
	wire logic wr_ctrl = wr & (av_req_in.address == OFS_CTRL);
	wire logic wr_src = wr & (av_req_in.address == OFS_SRC_FLAG);
	wire logic wr_sen = wr & (av_req_in.address == OFS_SRC_EN);
	wire logic wr_grp = wr & (av_req_in.address == OFS_GRP_FLAG);
	wire logic wr_gen = wr & (av_req_in.address == OFS_GRP_EN);
	wire logic [31:0] wmerge_ctrl = merge({31'h0, gie_q}, av_req_in.writedata, av_req_in.byteenable);
	wire logic [31:0] wmerge_src = merge(32'(src_flag_q), av_req_in.writedata, av_req_in.byteenable);
	wire logic [31:0] wmerge_sen = merge(32'(src_en_q), av_req_in.writedata, av_req_in.byteenable);
	wire logic [31:0] wmerge_grp = merge(32'(grp_flag_q), av_req_in.writedata, av_req_in.byteenable);
	wire logic [31:0] wmerge_gen = merge(32'(grp_en_q), av_req_in.writedata, av_req_in.byteenable);

	// read mux; unmapped offsets read zero
	wire logic [31:0] status_w = {21'h0, cout_q.wake, core_in.sleep, core_in.stack_full, 1'b0,
		GRP_W'(cout_q.grp_idx), 3'h0, cout_q.int_req};
	wire logic [31:0] rd_mux =
		(av_req_in.address == OFS_CTRL) ? {31'h0, gie_q} :
		(av_req_in.address == OFS_SRC_FLAG) ? 32'(src_flag_q) :
		(av_req_in.address == OFS_SRC_EN) ? 32'(src_en_q) :
		(av_req_in.address == OFS_GRP_FLAG) ? 32'(grp_flag_q) :
		(av_req_in.address == OFS_GRP_EN) ? 32'(grp_en_q) :
		(av_req_in.address == OFS_STATUS) ? status_w : 32'h0000_0000;

	// source set events in flag bit order
	wire logic [NUM_SRC-1:0] src_set = {etm_match_in,
		ctm_match_in,
		low_rise,
		nvm_write_done_in,
		pin_fall,
		spi2_byte_done_in,
		serial_byte_done_in};

	// software writes, then hardware set wins over a clear in the same cycle
	wire logic [NUM_SRC-1:0] src_wr_val = wr_src ? wmerge_src[NUM_SRC-1:0] : src_flag_q;
	wire logic [NUM_SRC-1:0] src_flag_d = src_wr_val | src_set;
	wire logic [NUM_SRC-1:0] src_rise = src_flag_d & ~src_flag_q;

	// service entry: core accepts the pending vector
	wire logic take = cout_q.int_req & core_in.ack;
	wire logic [NUM_GRP-1:0] take_clr = take ? NUM_GRP'(1) << cout_q.grp_idx : '0;

	// per-group set from members and ready for service
	logic [NUM_GRP-1:0] grp_set, grp_ready;
	genvar g;
	generate
		for (g = 0; g < NUM_GRP; g++) begin : g_grp
			assign grp_set[g] = |(src_rise & GRP_MASK[g]);
			assign grp_ready[g] = grp_flag_q[g] & grp_en_q[g] & |(src_flag_q & src_en_q & GRP_MASK[g]);
		end
	endgenerate

	// only the serviced group flag is cleared, sources untouched
	wire logic [NUM_GRP-1:0] grp_wr_val = wr_grp ? wmerge_grp[NUM_GRP-1:0] : grp_flag_q;
	wire logic [NUM_GRP-1:0] grp_flag_d = (grp_wr_val & ~take_clr) | grp_set;
	wire logic [NUM_GRP-1:0] grp_rise = grp_flag_d & ~grp_flag_q;

	logic pick_any;
	logic [GRP_W-1:0] pick_idx;
	mfi_grp_pick #(.N(NUM_GRP), .IW(GRP_W)) u_pick (
		.req_in(grp_ready),
		.any_out(pick_any),
		.idx_out(pick_idx)
	);

	// global enable: return-from-interrupt sets it, service entry clears it
	wire logic gie_wr = wr_ctrl ? wmerge_ctrl[CTRL_GIE] : gie_q;
	wire logic gie_d = core_in.return_from_interrupt ? 1'b1 :
		take ? 1'b0 : gie_wr;

	// request holds its vector until the core accepts it
	wire logic req_d = gie_q & ~core_in.stack_full & pick_any & ~take;
	wire logic [GRP_W-1:0] idx_d = (cout_q.int_req & ~take) ? cout_q.grp_idx : pick_idx;
	wire logic [11:0] vec_d = 12'(VEC_BASE + 12'(idx_d) * VEC_STEP);

	// wake on any flag rise while asleep, regardless of enables
	wire logic wake_d = core_in.sleep & (|src_rise | |grp_rise);

	// bus handshake: one wait cycle, then data and commit
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			wait_q <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else if (clk_en_in) begin
			wait_q <= ~((av_req_in.read | av_req_in.write) & wait_q);
			if (av_req_in.read & wait_q) begin
				rdata_q <= rd_mux;
			end
		end
	end

	// flag and enable storage
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			gie_q <= CTRL_GIE_RST;
			src_flag_q <= SRC_RST;
			src_en_q <= SRC_RST;
			grp_flag_q <= GRP_RST;
			grp_en_q <= GRP_RST;
		end else if (clk_en_in) begin
			gie_q <= gie_d;
			src_flag_q <= src_flag_d;
			grp_flag_q <= grp_flag_d;
			if (wr_sen) begin
				src_en_q <= wmerge_sen[NUM_SRC-1:0];
			end
			if (wr_gen) begin
				grp_en_q <= wmerge_gen[NUM_GRP-1:0];
			end
		end
	end

	// core side outputs; only the pc push is requested, no context save
	always_ff @(posedge sys_clk_in) begin
		if (!rst_b_in) begin
			cout_q <= '0;
		end else if (clk_en_in) begin
			cout_q.int_req <= req_d;
			cout_q.push_pc <= take;
			cout_q.wake <= wake_d;
			cout_q.grp_idx <= idx_d;
			cout_q.vec_addr <= vec_d;
		end
	end

	assign av_readdata_out = rdata_q;
	assign av_waitrequest_out = wait_q;
	assign core_out = cout_q;

	// wake needs sys_clk_in kept running; the sync flops run on it and are gated only by clk_en_in
	// (event pulses other than pin and supply are sampled directly, so one arriving while the clock is stopped is lost)

	property p_serial_set;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(serial_byte_done_in && clk_en_in) |=> src_flag_q[SRC_SERIAL];
	endproperty
	a_serial_set: assert property (p_serial_set) else $error("serial flag not set");

	property p_spi2_set;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(spi2_byte_done_in && clk_en_in) |=> src_flag_q[SRC_SPI2];
	endproperty
	a_spi2_set: assert property (p_spi2_set) else $error("spi2 flag not set");

	property p_req_gated;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		$rose(cout_q.int_req) |-> $past(gie_q) && !$past(core_in.stack_full)
			&& $past(grp_en_q[pick_idx]) && $past(|(src_flag_q & src_en_q));
	endproperty
	a_req_gated: assert property (p_req_gated) else $error("request without enables");

	property p_take_clears_gie;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(take && clk_en_in && !core_in.return_from_interrupt) |=> !gie_q ##1 (!gie_q || $past(core_in.return_from_interrupt || wr_ctrl));
	endproperty
	a_take_clears_gie: assert property (p_take_clears_gie) else $error("gie not cleared");

	property p_take_clears_group;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(take && clk_en_in && !grp_set[cout_q.grp_idx] && !wr_grp)
			|=> !grp_flag_q[$past(cout_q.grp_idx)] && ((src_flag_q & $past(src_flag_q)) == $past(src_flag_q) || $past(wr_src));
	endproperty
	a_take_clears_group: assert property (p_take_clears_group) else $error("service clear wrong");

	property p_pin_fall;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(pin_fall && clk_en_in) |=> src_flag_q[SRC_EXT];
	endproperty
	a_pin_fall: assert property (p_pin_fall) else $error("pin edge lost");

	property p_timer_set;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(clk_en_in && (ctm_match_in[0] || etm_match_in[2]))
			|=> (src_flag_q[SRC_CTM0] || !$past(ctm_match_in[0]))
			&& (src_flag_q[SRC_ETM0 + 2] || !$past(etm_match_in[2]));
	endproperty
	a_timer_set: assert property (p_timer_set) else $error("timer flag not set");

	property p_wake;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(core_in.sleep && clk_en_in && |(src_flag_d & ~src_flag_q)) |=> cout_q.wake;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on flag rise");

	property p_hold;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(clk_en_in && !wr_src) |=> (src_flag_q & $past(src_flag_q)) == $past(src_flag_q);
	endproperty
	a_hold: assert property (p_hold) else $error("source flag dropped");

	property p_group_set;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(clk_en_in && src_set[SRC_LOW] && !src_flag_q[SRC_LOW]) |=> grp_flag_q[5];
	endproperty
	a_group_set: assert property (p_group_set) else $error("group flag not set");

	property p_push;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(take && clk_en_in) |=> cout_q.push_pc && !cout_q.int_req;
	endproperty
	a_push: assert property (p_push) else $error("pc push missing");

	property p_return_from_interrupt;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(core_in.return_from_interrupt && clk_en_in) |=> gie_q;
	endproperty
	a_return_from_interrupt: assert property (p_return_from_interrupt) else $error("return_from_interrupt did not set gie");

	property p_prio;
		@(posedge sys_clk_in) disable iff (!rst_b_in)
		(clk_en_in && !cout_q.int_req && grp_ready[0] && gie_q && !core_in.stack_full) |=> cout_q.grp_idx == 3'h0;
	endproperty
	a_prio: assert property (p_prio) else $error("priority order wrong");
endmodule // mfi_top

// ---- tb_top.sv ----
`timescale 1ns/1ps
module tb_top import mfi_pkg::*; ;
	logic clk, rst_b, pin_n, sup, sfull, slp, wreq, ce;
	logic [3:0] dly;
	logic [14:0] ev;
	logic [31:0] rdata;
	logic [11:0] last_vec;
	mfi_av_req_s req;
	mfi_core_in_s cin;
	mfi_core_out_s cout;
	int push_cnt, wake_cnt, mismatches, total_checks;

	mfi_top dut (.sys_clk_in(clk), .rst_b_in(rst_b), .clk_en_in(ce), .av_req_in(req),
		.av_readdata_out(rdata), .av_waitrequest_out(wreq), .serial_byte_done_in(ev[0]),
		.spi2_byte_done_in(ev[1]), .periph_int_pin_n_in(pin_n), .nvm_write_done_in(ev[3]),
		.supply_low_in(sup), .ctm_match_in(ev[8:5]), .etm_match_in(ev[14:9]),
		.core_in(cin), .core_out(cout));
	mfi_core_model core (.clk_in(clk), .rst_b_in(rst_b), .core_out_in(cout), .ack_dly_in(dly),
		.stack_full_in(sfull), .sleep_in(slp), .core_in_out(cin), .push_cnt_out(push_cnt),
		.wake_cnt_out(wake_cnt), .last_vec_out(last_vec));

	// free running clock
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// one avalon transfer; request held until waitrequest is seen low
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		req <= {rd, !rd, a, 4'hf, d};
		do begin
			@(posedge clk);
			n++;
		end while (wreq && n < 50);
		q = rdata;
		if (n >= 50) mismatches++;
		req <= '0;
	endtask

	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b0, a, d, q);
	endtask

	task automatic rd(input logic [4:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b1, a, 32'h0, q);
		chk(q, exp);
	endtask

	function automatic int grp_of(input int i);
		for (int g = 0; g < NUM_GRP; g++) if (GRP_MASK[g][i]) return g;
		return 0;
	endfunction

	// raise one source; the pin and supply inputs pass a synchroniser, so give them time
	task automatic fire(input int i);
		if (i == SRC_EXT) begin
			// shared pin is taken as already routed to the peripheral input
			pin_n <= 1'b0;
			repeat (8) @(posedge clk);
			pin_n <= 1'b1;
		end else if (i == SRC_LOW) begin
			sup <= 1'b1;
			repeat (8) @(posedge clk);
			sup <= 1'b0;
		end else begin
			ev[i] <= 1'b1;
			@(posedge clk);
			ev[i] <= 1'b0;
		end
		repeat (8) @(posedge clk);
	endtask

	task automatic wait_push(input int n);
		int k = 0;
		while (push_cnt < n && k < 100) begin
			@(posedge clk);
			k++;
		end
		chk(32'(push_cnt), 32'(n));
	endtask

	task automatic t_reset;
		logic [31:0] q;
		chk(32'(cout), 32'h0);
		chk(32'(wreq), 32'h1);
		chk(rdata, 32'h0);
		bus(1'b0, 5'h18, 32'hffffffff, q);
		bus(1'b0, OFS_STATUS, 32'hffffffff, q);
		for (int a = 0; a <= 24; a += 4) rd(5'(a), 32'h0);
	endtask

	// clock enable low freezes the block, so a byte done pulse is lost
	task automatic t_freeze;
		ce <= 1'b0;
		fire(SRC_SERIAL);
		ce <= 1'b1;
		rd(OFS_SRC_FLAG, 32'h0);
	endtask

	// every source in turn while asleep, enables all off
	task automatic t_sources;
		int w0;
		slp <= 1'b1;
		for (int i = 0; i < NUM_SRC; i++) begin
			w0 = wake_cnt;
			fire(i);
			rd(OFS_SRC_FLAG, 32'h1 << i);
			rd(OFS_GRP_FLAG, 32'h1 << grp_of(i));
			chk(32'(wake_cnt), 32'(w0 + 1));
			wr(OFS_SRC_FLAG, 32'h0);
			wr(OFS_GRP_FLAG, 32'h0);
		end
		rd(OFS_STATUS, 32'h200);
		slp <= 1'b0;
	endtask

	// a flag set high before sleep cannot rise again, so no wake
	task automatic t_mask_wake;
		int w0;
		wr(OFS_SRC_FLAG, 32'h1 << SRC_NVM);
		slp <= 1'b1;
		w0 = wake_cnt;
		fire(SRC_NVM);
		chk(32'(wake_cnt), 32'(w0));
		rd(OFS_SRC_FLAG, 32'h1 << SRC_NVM);
		slp <= 1'b0;
		wr(OFS_SRC_FLAG, 32'h0);
		wr(OFS_GRP_FLAG, 32'h0);
	endtask

	task automatic t_service;
		int p0 = push_cnt;
		dly <= 4'h5;
		wr(OFS_SRC_EN, 32'h7fff);
		wr(OFS_GRP_EN, 32'h3f);
		wr(OFS_CTRL, 32'h1);
		fire(SRC_SPI2);
		wait_push(p0 + 1);
		chk(32'(last_vec), 32'(VEC_BASE) + 32'(VEC_STEP) * grp_of(SRC_SPI2));
		rd(OFS_CTRL, 32'h0);
		rd(OFS_SRC_FLAG, 32'h1 << SRC_SPI2);
		rd(OFS_GRP_FLAG, 32'h0);
		core.ret_int();
		rd(OFS_CTRL, 32'h1);
		repeat (10) @(posedge clk);
		chk(32'(push_cnt), 32'(p0 + 1));
		wr(OFS_SRC_FLAG, 32'h0);
	endtask

	// each missing condition alone must hold off the vector, the pending flag stays
	task automatic t_gating;
		int p0 = push_cnt;
		dly <= 4'h0;
		wr(OFS_CTRL, 32'h0);
		wr(OFS_SRC_FLAG, 32'h1 << SRC_LOW);
		for (int c = 0; c < 5; c++) begin
			wr(OFS_CTRL, 32'h0);
			sfull <= (c == 3);
			wr(OFS_SRC_EN, (c == 1) ? 32'h0 : 32'h7fff);
			wr(OFS_GRP_EN, (c == 2) ? 32'h0 : 32'h3f);
			wr(OFS_CTRL, (c == 0) ? 32'h0 : 32'h1);
			if (c < 4) begin
				repeat (20) @(posedge clk);
				chk(32'(push_cnt), 32'(p0));
				rd(OFS_SRC_FLAG, 32'h1 << SRC_LOW);
			end
		end
		wait_push(p0 + 1);
		chk(32'(last_vec), 32'(VEC_BASE) + 32'(VEC_STEP) * grp_of(SRC_LOW));
		wr(OFS_SRC_FLAG, 32'h0);
	endtask

	// two groups pending together: lower vector first
	task automatic t_priority;
		int p0 = push_cnt;
		ev <= 15'h00a0;
		@(posedge clk);
		ev <= 15'h0000;
		repeat (4) @(posedge clk);
		core.ret_int();
		wait_push(p0 + 1);
		chk(32'(last_vec), 32'(VEC_BASE) + 32'(VEC_STEP) * grp_of(5));
		core.ret_int();
		wait_push(p0 + 2);
		chk(32'(last_vec), 32'(VEC_BASE) + 32'(VEC_STEP) * grp_of(7));
	endtask

	task automatic test_done;
		$display("checks=%0d mismatches=%0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#50000;
		mismatches++;
		test_done();
	end

	// main sequence
	initial begin
		req = '0;
		ev = 15'h0;
		pin_n = PIN_IDLE;
		sup = 1'b0;
		ce = 1'b1;
		sfull = 1'b0;
		slp = 1'b0;
		dly = 4'h0;
		rst_b = 1'b0;
		mismatches = 0;
		total_checks = 0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		t_reset();
		t_freeze();
		t_sources();
		t_mask_wake();
		t_service();
		t_gating();
		t_priority();
		test_done();
	end
endmodule // tb_top
